//--- rtl/pcw_pkg.sv
package pcw_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_RISE_EN   = 4'h0;
    localparam logic [3:0] ADDR_FALL_EN   = 4'h1;
    localparam logic [3:0] ADDR_FLAGS     = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h3;
    localparam logic [3:0] ADDR_WAKE_EN   = 4'h4;
    localparam logic [3:0] ADDR_WAKE_STAT = 4'h5;
    localparam logic [3:0] ADDR_CTRL      = 4'h6;

    // Reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] RST_NIB   = 4'h0;

    // Wake source bit positions
    localparam int WK_PORT  = 0;
    localparam int WK_EXT   = 1;
    localparam int WK_PERIPH = 2;
    localparam int WK_WDOG  = 3;

    // Control register bit positions
    localparam int CTRL_GIE      = 0;
    localparam int CTRL_SLEEP    = 1;
    localparam int CTRL_PIN_RST  = 2;
    localparam int CTRL_BOR_EN   = 3;
    localparam int CTRL_WDOG_EN  = 4;

    typedef enum logic [2:0] {
        PCW_RUN,
        PCW_SLEEP,
        PCW_WAKE_NEXT,
        PCW_WAKE_ISR,
        PCW_RESET
    } pcw_state_t;
endpackage

//--- rtl/pcw_core.sv
`timescale 1ns/1ns
`default_nettype none
module pcw_core (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic [7:0]       i_port_pin,
    input  wire logic [3:0]       i_addr,
    input  wire logic [7:0]       i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic             i_ext_irq,
    input  wire logic             i_periph_irq,
    input  wire logic             i_wdog_timeout,
    input  wire logic             i_pin_reset,
    input  wire logic             i_brownout,
    input  wire logic             i_power_on,
    input  wire logic             i_sleep_instr,
    output logic [7:0]            o_rdata,
    output logic                  o_irq,
    output logic                  o_sleeping,
    output logic                  o_prefetch_next,
    output logic                  o_resume_next,
    output logic                  o_isr_branch,
    output logic                  o_device_reset,
    output logic                  o_wdog_clear,
    output pcw_pkg::pcw_state_t   o_state
);
    import pcw_pkg::*;

    logic [7:0] rise_en_q;
    logic [7:0] fall_en_q;
    logic [7:0] flags_q;
    logic [7:0] pin_q;
    logic [7:0] irq_mask_q;
    logic [3:0] wake_en_q;
    logic [3:0] wake_stat_q;
    logic [4:0] ctrl_q;
    logic [7:0] rdata_q;
    logic [7:0] rise_hit;
    logic [7:0] fall_hit;
    logic [7:0] flags_d;
    logic [3:0] wake_src;
    logic       irq_wake;
    logic       rst_wake;
    logic       wk_reset_q;
    pcw_state_t state_q;

    function automatic logic wr_at(input logic [3:0] a);
        wr_at = i_wr && (i_addr == a);
    endfunction

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pin_q <= RST_BYTE;
        end else begin
            pin_q <= i_port_pin;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign rise_hit[g] = rise_en_q[g] && i_port_pin[g] && !pin_q[g];
            assign fall_hit[g] = fall_en_q[g] && !i_port_pin[g] && pin_q[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Change flags
    // ------------------------------------------------------------
    always_comb begin
        flags_d = flags_q;
        // cleared only by write of one
        if (wr_at(ADDR_FLAGS)) begin
            flags_d = flags_d & ~i_wdata;
        end
        // rising or falling edge sets flag, set wins over clear
        flags_d = flags_d | rise_hit;
        flags_d = flags_d | fall_hit;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            flags_q <= RST_BYTE;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign o_irq = |(flags_q & irq_mask_q);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rise_en_q  <= RST_BYTE;
            fall_en_q  <= RST_BYTE;
            irq_mask_q <= RST_BYTE;
            wake_en_q  <= RST_NIB;
            ctrl_q     <= 5'h00;
        end else begin
            if (wr_at(ADDR_RISE_EN)) begin
                rise_en_q <= i_wdata;
            end
            if (wr_at(ADDR_FALL_EN)) begin
                fall_en_q <= i_wdata;
            end
            if (wr_at(ADDR_IRQ_MASK)) begin
                irq_mask_q <= i_wdata;
            end
            if (wr_at(ADDR_WAKE_EN)) begin
                wake_en_q <= i_wdata[3:0];
            end
            if (wr_at(ADDR_CTRL)) begin
                ctrl_q <= i_wdata[4:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_RISE_EN:   rdata_q <= rise_en_q;
                ADDR_FALL_EN:   rdata_q <= fall_en_q;
                ADDR_FLAGS:     rdata_q <= flags_q;
                ADDR_IRQ_MASK:  rdata_q <= irq_mask_q;
                ADDR_WAKE_EN:   rdata_q <= {4'h0, wake_en_q};
                ADDR_WAKE_STAT: rdata_q <= {4'h0, wake_stat_q};
                ADDR_CTRL:      rdata_q <= {3'h0, ctrl_q};
                default:        rdata_q <= RST_BYTE;
            endcase
        end else begin
            rdata_q <= RST_BYTE;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // Wake control
    // ------------------------------------------------------------
    // each source gated by its own enable except power-on
    assign wake_src[WK_PORT]   = o_irq && wake_en_q[WK_PORT];
    assign wake_src[WK_EXT]    = i_ext_irq && wake_en_q[WK_EXT];
    assign wake_src[WK_PERIPH] = i_periph_irq && wake_en_q[WK_PERIPH];
    assign wake_src[WK_WDOG]   = i_wdog_timeout && ctrl_q[CTRL_WDOG_EN];
    assign irq_wake = |wake_src;
    assign rst_wake = (i_pin_reset && ctrl_q[CTRL_PIN_RST])
                   || (i_brownout && ctrl_q[CTRL_BOR_EN])
                   || i_power_on;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= PCW_RUN;
        end else begin
            case (state_q)
                PCW_RUN: begin
                    if (rst_wake) begin
                        state_q <= PCW_RESET;
                    end else if (i_sleep_instr) begin
                        state_q <= PCW_SLEEP;
                    end
                end
                PCW_SLEEP: begin
                    if (rst_wake) begin
                        state_q <= PCW_RESET;
                    end else if (irq_wake && ctrl_q[CTRL_GIE]) begin
                        state_q <= PCW_WAKE_ISR;
                    end else if (irq_wake) begin
                        state_q <= PCW_WAKE_NEXT;
                    end
                end
                PCW_WAKE_NEXT: state_q <= PCW_RUN;
                PCW_WAKE_ISR:  state_q <= PCW_RUN;
                PCW_RESET:     state_q <= PCW_RUN;
                default:       state_q <= PCW_RUN;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_stat_q <= RST_NIB;
        end else if (state_q == PCW_SLEEP && !rst_wake && irq_wake) begin
            wake_stat_q <= wake_src;
        end else if (wr_at(ADDR_WAKE_STAT)) begin
            wake_stat_q <= wake_stat_q & ~i_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wk_reset_q <= 1'b0;
        end else begin
            wk_reset_q <= (state_q == PCW_SLEEP) && rst_wake;
        end
    end

    assign o_sleeping      = (state_q == PCW_SLEEP);
    // prefetch PC plus one during sleep instruction
    assign o_prefetch_next = (state_q == PCW_RUN) && i_sleep_instr;
    assign o_resume_next   = (state_q == PCW_WAKE_NEXT)
                          || (state_q == PCW_WAKE_ISR);
    assign o_isr_branch    = (state_q == PCW_WAKE_ISR);
    assign o_device_reset  = (state_q == PCW_RESET);
    // watchdog cleared on any sleep exit
    assign o_wdog_clear    = (state_q == PCW_SLEEP)
                          && (rst_wake || irq_wake);
    assign o_state         = state_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rise_sets_flag: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (rise_en_q[0] && i_port_pin[0] && !pin_q[0]) |=> flags_q[0])
        else $error("rising edge did not set flag");
    chk_fall_sets_flag: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (fall_en_q[1] && !i_port_pin[1] && pin_q[1]) |=> flags_q[1])
        else $error("falling edge did not set flag");
    chk_rise_disarmed: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!rise_en_q[2] && !fall_en_q[2] && !flags_q[2]) |=> !flags_q[2])
        else $error("disarmed pin flag set");
    chk_fall_disarmed: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!fall_en_q[3] && !flags_q[3] && !(i_port_pin[3] && !pin_q[3]))
        |=> !flags_q[3])
        else $error("falling disarmed yet flag set");
    chk_flag_sticky: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (flags_q[4] && !wr_at(ADDR_FLAGS)) |=> flags_q[4])
        else $error("flag dropped without clear");
    chk_irq_level: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_irq == |(flags_q & irq_mask_q))
        else $error("irq does not follow flags");
    chk_reset_wake: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && rst_wake) |=> o_device_reset && !o_resume_next)
        else $error("reset wake did not reset");
    chk_resume_wake: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && irq_wake)
        |=> o_resume_next && !o_device_reset ##1 state_q == PCW_RUN)
        else $error("interrupt wake did not resume");
    chk_gie_isr: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && irq_wake && ctrl_q[CTRL_GIE])
        |=> o_isr_branch)
        else $error("no isr branch with global enable");
    chk_gie_clear: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && irq_wake && !ctrl_q[CTRL_GIE])
        |=> !o_isr_branch && o_resume_next)
        else $error("isr branch without global enable");
    chk_wdog_clear: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping ##1 !o_sleeping) |-> $past(o_wdog_clear))
        else $error("sleep exit without watchdog clear");
    chk_wake_gated: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && !wake_en_q[WK_EXT] && !wake_en_q[WK_PORT]
         && !wake_en_q[WK_PERIPH] && !i_wdog_timeout) |=> o_sleeping)
        else $error("disabled source woke device");

    // ------------------------------------------------------------
    // Flag, wake and register checks
    // ------------------------------------------------------------
    chk_rise_off: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !rise_en_q[0] |-> !rise_hit[0])
        else $error("rise hit while disarmed");
    chk_set_wins: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (wr_at(ADDR_FLAGS) && rise_hit[6]) |=> flags_q[6])
        else $error("clear beat rising set");
    chk_fall_wins: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (wr_at(ADDR_FLAGS) && fall_hit[7]) |=> flags_q[7])
        else $error("clear beat falling set");
    chk_clear_works: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (wr_at(ADDR_FLAGS) && i_wdata[5] && !rise_hit[5] && !fall_hit[5])
        |=> !flags_q[5])
        else $error("write of one did not clear flag");
    chk_flag_read: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_rd && i_addr == ADDR_FLAGS) |=> o_rdata == $past(flags_q))
        else $error("flag read wrong");
    chk_irq_held: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_irq && !wr_at(ADDR_FLAGS) && !wr_at(ADDR_IRQ_MASK)) |=> o_irq)
        else $error("irq dropped without clear");
    chk_wake_any: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && (rst_wake || irq_wake)) |=> !o_sleeping)
        else $error("wake event ignored");
    chk_sleep_hold: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && !irq_wake) |=> o_sleeping)
        else $error("left sleep without event");
    chk_reset_flop: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        wk_reset_q |-> o_device_reset)
        else $error("reset wake not followed by reset");
    chk_reset_one: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_device_reset |=> state_q == PCW_RUN)
        else $error("reset pulse too long");
    chk_sleep_entry: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state_q == PCW_RUN && i_sleep_instr && !rst_wake) |=> o_sleeping)
        else $error("sleep instruction not taken");
    chk_prefetch_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_sleep_instr |-> !o_prefetch_next)
        else $error("prefetch without sleep instruction");
    chk_wake_stat: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && irq_wake)
        |=> wake_stat_q == $past(wake_src))
        else $error("wake sources not recorded");
    chk_ext_wake: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_sleeping && !rst_wake && i_ext_irq && wake_en_q[WK_EXT])
        |=> o_resume_next)
        else $error("enabled interrupt did not wake");
    chk_isr_gie: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_isr_branch |-> $past(ctrl_q[CTRL_GIE]))
        else $error("isr branch with global enable clear");
    chk_isr_next: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_isr_branch |-> o_resume_next ##1 state_q == PCW_RUN)
        else $error("isr branch without next instruction");
    chk_wdog_awake: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !o_sleeping |-> !o_wdog_clear)
        else $error("watchdog cleared while awake");
endmodule
`default_nettype wire

//--- sim/pcw_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pin driver: follows the goal after a lag
// ----------------------------------------
module pcw_pin_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_goal,
    input  wire logic [3:0] i_lag,
    output logic      [7:0] o_pin
);
    logic [7:0] pin_q = 8'h00;
    logic [3:0] wait_q = 4'h0;

    assign o_pin = pin_q;

    // Slow or prompt answer, as the lag asks
    always @(posedge i_sys_clk) begin
        if (pin_q == i_goal) begin
            wait_q <= i_lag;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else begin
            pin_q <= i_goal;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_pcw_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pcw_core;
    import pcw_pkg::*;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_sleep_instr = 1'b0;
    logic [5:0] srcs = 6'h00;
    logic [7:0] goal = 8'h00;
    logic [3:0] lag = 4'h0;
    logic [7:0] i_port_pin;
    logic [7:0] o_rdata;
    logic       o_irq;
    logic       o_sleeping;
    logic       o_prefetch;
    logic       o_resume;
    logic       o_isr;
    logic       o_dev_rst;
    logic       o_wdog_clr;
    int         n_mismatch = 0;
    int         comparisons = 0;
    logic [7:0] rd_q[$];
    logic [2:0] wake_q[$];
    logic       rd_p = 1'b0;
    logic [7:0] rise;
    logic [7:0] fall;

    always #5 i_sys_clk = ~i_sys_clk;

    pcw_pin_model pcw_pin_model_i (.i_sys_clk(i_sys_clk), .i_goal(goal),
        .i_lag(lag), .o_pin(i_port_pin));

    pcw_core pcw_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_port_pin(i_port_pin), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_ext_irq(srcs[0]),
        .i_periph_irq(srcs[1]), .i_wdog_timeout(srcs[2]),
        .i_pin_reset(srcs[3]), .i_brownout(srcs[4]), .i_power_on(srcs[5]),
        .i_sleep_instr(i_sleep_instr), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_sleeping(o_sleeping), .o_prefetch_next(o_prefetch),
        .o_resume_next(o_resume), .o_isr_branch(o_isr),
        .o_device_reset(o_dev_rst), .o_wdog_clear(o_wdog_clr), .o_state());

    // ----------------------------------------
    // Compare, verdict and bus tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
    endtask

    task automatic pins(input logic [7:0] v);
        int k;
        goal <= v;
        lag <= 4'($urandom_range(0, 3));
        for (k = 0; k < 20 && i_port_pin !== v; k++) @(posedge i_sys_clk);
        if (k == 20) begin
            n_mismatch++;
            summarize();
        end
        repeat (4) @(posedge i_sys_clk);
    endtask

    task automatic chk_irq(input logic e);
        @(posedge i_sys_clk);
        #1 cmp("irq", {7'h00, e}, {7'h00, o_irq});
    endtask

    task automatic cfg(input logic global_interrupt_enable);
        wr(ADDR_WAKE_EN, 8'h06);
        wr(ADDR_CTRL, {7'h0e, global_interrupt_enable});
    endtask

    task automatic nap;
        @(posedge i_sys_clk);
        i_sleep_instr <= 1'b1;
        #1 cmp("prefetch", 8'h01, {7'h00, o_prefetch});
        @(posedge i_sys_clk);
        i_sleep_instr <= 1'b0;
        #1 cmp("sleeping", 8'h01, {7'h00, o_sleeping});
    endtask

    task automatic kick(input int src, input logic [2:0] e);
        @(posedge i_sys_clk);
        srcs <= 6'h01 << src;
        #1 cmp("wdog clear", {7'h00, |e}, {7'h00, o_wdog_clr});
        if (e != 3'h0) wake_q.push_back(e);
        @(posedge i_sys_clk);
        srcs <= 6'h00;
        repeat (3) @(posedge i_sys_clk);
        #1 cmp("asleep", {7'h00, e == 3'h0}, {7'h00, o_sleeping});
    endtask

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge i_sys_clk) begin
        rd_p <= i_rd;
        if (rd_p) cmp("read data", rd_q.pop_front(), o_rdata);
        if (o_resume | o_dev_rst)
            cmp("wake kind", {5'h00, wake_q.pop_front()},
                {5'h00, o_resume, o_isr, o_dev_rst});
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(37));
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(ADDR_RISE_EN, RST_BYTE);
        rd(ADDR_FALL_EN, RST_BYTE);
        rd(ADDR_FLAGS, RST_BYTE);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        wr(ADDR_IRQ_MASK, 8'hff);
        rise = 8'($urandom());
        for (int p = 0; p < 2; p++) begin
            fall = p ? 8'h00 : ~rise;
            rise = p ? ~rise : rise;
            wr(ADDR_RISE_EN, rise);
            wr(ADDR_FALL_EN, fall);
            rd(ADDR_FALL_EN, fall);
            for (int i = 0; i < 8; i++) begin
                wr(ADDR_FLAGS, 8'hff);
                pins(8'h01 << i);
                rd(ADDR_FLAGS, rise & (8'h01 << i));
                chk_irq(rise[i]);
                pins(8'h00);
                rd(ADDR_FLAGS, (rise | fall) & (8'h01 << i));
            end
        end
        wr(ADDR_FLAGS, 8'hff);
        rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_RISE_EN, 8'hff);
        pins(8'hff);
        wr(ADDR_IRQ_MASK, 8'h00);
        chk_irq(1'b0);
        wr(ADDR_IRQ_MASK, 8'hff);
        chk_irq(1'b1);
        wr(ADDR_FLAGS, 8'hff);
        chk_irq(1'b0);
        cfg(1'b0);
        nap();
        kick(0, 3'b100);
        rd(ADDR_WAKE_STAT, 8'h01 << WK_EXT);
        cfg(1'b1);
        nap();
        kick(1, 3'b110);
        cfg(1'b0);
        nap();
        kick(2, 3'b100);
        wr(ADDR_WAKE_EN, 8'h00);
        nap();
        kick(0, 3'b000);
        kick(5, 3'b001);
        cfg(1'b0);
        nap();
        kick(3, 3'b001);
        cfg(1'b1);
        nap();
        kick(4, 3'b001);
        rd(ADDR_CTRL, {7'h0e, 1'b1});
        repeat (3) @(posedge i_sys_clk);
        summarize();
    end
endmodule
`default_nettype wire
